// File: mrp_mode_regs.sv
// Mode register programming: captures register set commands on the command
// clock, moves them into the core clock domain and keeps the seven registers.
// Assumes the controller keeps the command spacing and idle-state conditions.
`timescale 1ns/1ps
`include "mrp_consts.svh"

// Notes on behaviour
// [R1] Seven mode registers, changed only by register set commands, rewritable anytime.
// [R2] Controller writes every register after power-up or reset before use.
// [R3] Controller drives every field of the addressed register on each command.
// [R4] Register set and DLL reset never touch array contents.
// [R5] Controller spaces register set commands by at least the cycle gap.
// [R6] Special function changes wait for completion instead of the cycle gap.
// [R7] Controller waits the update delay before non register set commands.
// [R8] Some settings follow their own delays instead of the update delay.
// [R9] Register sets only while idle, banks precharged, clock enable high.
// [R10] With termination enabled, its control stays low until update delay ends.
// [R11] With termination disabled around a set, its control is free.
// [R12] Register set is the four strobes low; pins map onto bits 21:0.
// [R13] Bits 20:18 pick register zero to six; code seven is unused.
// [R14] Bits 13,11:9 pick write recovery and read-to-precharge pairs.
// [R15] Controller programs 28/14 when needs exceed those counts.
// [R16] Bit 8 set triggers a DLL reset; clear leaves it alone.
// [R17] Controller keeps bit 7 at zero for normal operation.
// [R18] Bits 12,6:4,2 pick read latency from 9 to 32 clocks.
// [R19] Controller avoids odd latencies in quarter-rate gear-down mode.
// [R20] Bit 3 picks nibble-sequential or interleaved burst order.
// [R21] Bits 1:0 pick fixed eight, on-the-fly, fixed chopped four, reserved.
// [R22] Controller programs reserved bits 21 and 17 to zero.
// [R23] The stored DLL reset bit clears itself once the reset is issued.
// [R24] No half-clock latencies; total latency is additive plus programmed.
// [R25] Capture at the command edge, apply settings after the update delay.
module mrp_mode_regs #(
  parameter int UPDATE_CYC = `MRP_UPDATE_CYC,
  parameter int GAP_NCK = `MRP_GAP_NCK
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_clk,
  input wire mrp_pkg::mrp_cmd_pins_t cmd_pins,
  output logic [`MRP_NUM_REGS-1:0][`MRP_WORD_W-1:0] mode_regs,
  output mrp_pkg::mrp_cfg_t cfg,
  output logic dll_reset_pulse,
  output logic update_busy,
  output logic set_gap_error,
  output logic unused_select_seen,
  output logic reserved_code_seen
);
  import mrp_pkg::*;

  // Elaboration check: counters below are 16 bits and need at least one cycle.
  if (UPDATE_CYC < 1 || UPDATE_CYC > 65535 || GAP_NCK < 1 || GAP_NCK > 65535) begin : g_chk
    $error("mrp_mode_regs: timing parameter out of range");
  end

  localparam logic [15:0] UPD_LOAD = 16'(UPDATE_CYC - 1);
  localparam logic [15:0] GAP_LOAD = 16'(GAP_NCK - 1);

  // State on the command clock.
  typedef struct packed {
    logic [`MRP_WORD_W-1:0] word;
    logic tgl;
    logic [15:0] gap_cnt;
    logic gap_err;
  } mrp_link_st_t;

  // State on the core clock.
  typedef struct packed {
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic err_s1;
    logic err_s2;
    logic [`MRP_NUM_REGS-1:0][`MRP_WORD_W-1:0] regs;
    logic [`MRP_WORD_W-1:0] pend;
    mrp_state_t state;
    logic [15:0] cnt;
    mrp_cfg_t cfg;
    logic dll_pulse;
    logic unused_sel;
    logic rsvd_code;
  } mrp_core_st_t;

  mrp_link_st_t link;
  mrp_link_st_t next_link;
  mrp_core_st_t core;
  mrp_core_st_t next_core;

  // Write recovery / read-to-precharge pairs; code 6 and 7 are not monotonic.
  function automatic logic [9:0] wr_decode(input logic [3:0] code);
    logic [9:0] r;
    r = {1'b0, 9'h0};
    unique case (code)
      4'h6: r = {1'b1, 5'd24, 4'd12};
      4'h7: r = {1'b1, 5'd22, 4'd11};
      4'h8: r = {1'b1, 5'd26, 4'd13};
      4'h9: r = {1'b1, 5'd28, 4'd14};
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
        r = {1'b1, 5'(5'd10 + {code, 1'b0}), 4'(4'd5 + code)};
      default: r = {1'b0, 9'h0};
    endcase
    return r;
  endfunction

  // Read latency table; codes 8 to 15 are out of order on purpose.
  function automatic logic [6:0] rl_decode(input logic [4:0] code);
    logic [6:0] r;
    r = 7'h0;
    unique case (code)
      5'h08: r = {1'b1, 6'd18};
      5'h09: r = {1'b1, 6'd20};
      5'h0a: r = {1'b1, 6'd22};
      5'h0b: r = {1'b1, 6'd24};
      5'h0c: r = {1'b1, 6'd23};
      5'h0d: r = {1'b1, 6'd17};
      5'h0e: r = {1'b1, 6'd19};
      5'h0f: r = {1'b1, 6'd21};
      default: begin
        if (code <= 5'h07) begin
          r = {1'b1, 6'(6'd9 + {1'b0, code})};
        end else if (code <= `MRP_RL_CODE_MAX) begin
          r = {1'b1, 6'(6'd9 + {1'b0, code})};
        end
      end
    endcase
    return r;
  endfunction

  // Command clock side: decode the strobes, latch the pin word, flip the toggle.
  always_comb begin
    logic is_set;
    is_set = 1'b0;
    next_link = link;
    is_set = !cmd_pins.cs_n && !cmd_pins.ras_n && !cmd_pins.cas_n
             && !cmd_pins.we_n; // [R12]
    if (link.gap_cnt != 16'h0) begin
      next_link.gap_cnt = link.gap_cnt - 16'h1;
    end
    if (is_set) begin
      // Pin to bit mapping; bits 16:14 have no pin and stay zero.
      next_link.word = {cmd_pins.group_select_pins, cmd_pins.bank,
                        cmd_pins.addr[17], 3'h0, cmd_pins.addr[13:0]}; // [R12]
      next_link.tgl = ~link.tgl;
      next_link.gap_cnt = GAP_LOAD;
      // The controller owns the spacing; the device only records a breach.
      if (link.gap_cnt != 16'h0) begin
        next_link.gap_err = 1'b1; // [R5]
      end
    end
  end

  always_ff @(posedge cmd_clk or negedge rst_n) begin
    if (!rst_n) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // Core side: the latched word is held stable until the next command, and
  // the spacing rule keeps it stable well past the three-flop toggle crossing.
  always_comb begin
    logic [2:0] sel;
    logic [`MRP_WORD_W-1:0] w;
    logic [9:0] wr;
    logic [6:0] rl;
    sel = 3'h0;
    w = '0;
    wr = '0;
    rl = '0;
    next_core = core;
    next_core.tgl_s1 = link.tgl;
    next_core.tgl_s2 = core.tgl_s1;
    next_core.tgl_s3 = core.tgl_s2;
    next_core.err_s1 = link.gap_err;
    next_core.err_s2 = core.err_s1;
    next_core.dll_pulse = 1'b0;
    w = link.word;
    sel = w[`MRP_SEL_LSB+2:`MRP_SEL_LSB];
    // Update sequencer: hold new settings back for the update delay.
    unique case (core.state)
      MRP_IDLE: begin
      end
      MRP_HOLD: begin
        if (core.cnt != 16'h0) begin
          next_core.cnt = core.cnt - 16'h1;
        end else begin
          wr = wr_decode({core.pend[`MRP_WR_HI_BIT], core.pend[11:9]});
          rl = rl_decode({core.pend[`MRP_RL_HI_BIT], core.pend[6:4],
                          core.pend[`MRP_RL_LO_BIT]});
          // Reserved codes keep the previous setting and raise a flag.
          if (wr[9]) begin
            next_core.cfg.write_recovery = wr[8:4]; // [R14]
            next_core.cfg.read_to_precharge_delay = wr[3:0]; // [R14]
          end else begin
            next_core.rsvd_code = 1'b1;
          end
          // Whole clocks only; additive latency is added downstream.
          if (rl[6]) begin
            next_core.cfg.read_data_latency = rl[5:0]; // [R18] [R24]
          end else begin
            next_core.rsvd_code = 1'b1;
          end
          next_core.cfg.burst_ordering = core.pend[`MRP_ORDER_BIT]; // [R20]
          if (core.pend[1:0] != `MRP_BURST_RSVD) begin
            next_core.cfg.burst_size_select = core.pend[1:0]; // [R21]
          end else begin
            next_core.rsvd_code = 1'b1;
          end
          next_core.cfg.factory_test_select = core.pend[`MRP_TEST_BIT];
          next_core.state = MRP_IDLE; // [R25]
        end
      end
    endcase
    // A new command arrives: route it by the select code.
    if (core.tgl_s2 != core.tgl_s3) begin
      if (sel == `MRP_SEL_UNUSED) begin
        next_core.unused_sel = 1'b1; // [R13]
      end else begin
        // Only the mode registers change; nothing here reaches the array.
        next_core.regs[sel] = w; // [R1] [R4] [R13]
        if (sel == `MRP_SEL_BASE) begin
          next_core.pend = w; // [R25]
          next_core.cnt = UPD_LOAD;
          next_core.state = MRP_HOLD;
          if (w[`MRP_DLL_RST_BIT]) begin
            next_core.dll_pulse = 1'b1; // [R16]
            next_core.regs[sel][`MRP_DLL_RST_BIT] = 1'b0; // [R23]
          end
        end
      end
    end
  end

  // Reset values match the all-zero field codes of the base register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core <= '0;
      core.state <= MRP_IDLE;
      core.cfg.write_recovery <= `MRP_RST_WR;
      core.cfg.read_to_precharge_delay <= `MRP_RST_RTP;
      core.cfg.read_data_latency <= `MRP_RST_RL;
      core.cfg.burst_size_select <= `MRP_RST_BURST;
    end else begin
      core <= next_core;
    end
  end

  // Every output comes straight from a core-domain flop.
  assign mode_regs = core.regs;
  assign cfg = core.cfg;
  assign dll_reset_pulse = core.dll_pulse;
  // One-hot code: the hold bit is the busy flag itself, so no logic follows the flop.
  assign update_busy = core.state[1];
  assign set_gap_error = core.err_s2;
  assign unused_select_seen = core.unused_sel;
  assign reserved_code_seen = core.rsvd_code;
endmodule

// File: mrp_consts.svh
// Constants for the mode register programming block: field positions,
// reset values and timing counts.
// Assumes a 25 MHz core clock and a separate command clock from the controller.
`ifndef MRP_CONSTS_SVH
`define MRP_CONSTS_SVH

// Register file shape.
`define MRP_WORD_W 22
`define MRP_NUM_REGS 7
`define MRP_SEL_LSB 18
`define MRP_SEL_UNUSED 3'h7
`define MRP_SEL_BASE 3'h0

// Field positions inside the base operating mode register.
`define MRP_RES_HI_BIT 21
`define MRP_RES_LO_BIT 17
`define MRP_WR_HI_BIT 13
`define MRP_RL_HI_BIT 12
`define MRP_DLL_RST_BIT 8
`define MRP_TEST_BIT 7
`define MRP_ORDER_BIT 3
`define MRP_RL_LO_BIT 2

// Codes and reset values of the decoded settings.
`define MRP_WR_CODE_MAX 4'h9
`define MRP_RL_CODE_MAX 5'h17
`define MRP_BURST_RSVD 2'h3
`define MRP_RST_WR 5'h0a
`define MRP_RST_RTP 4'h5
`define MRP_RST_RL 6'h09
`define MRP_RST_BURST 2'h0

// Timing: core clock period and the register update delay.
`define MRP_CLK_PERIOD_PS 40000
`define MRP_UPDATE_DELAY_NS 1000
`define MRP_UPDATE_CYC \
  ((`MRP_UPDATE_DELAY_NS * 1000 + `MRP_CLK_PERIOD_PS - 1) / `MRP_CLK_PERIOD_PS)
// Least spacing between two register set commands, in command clocks.
`define MRP_GAP_NCK 8

`endif

// File: mrp_pkg.sv
// Types shared by the mode register programming block.
// Assumes mrp_consts.svh is on the include path.
package mrp_pkg;
  `include "mrp_consts.svh"

  // Command and address pins as seen on the command clock.
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] group_select_pins;
    logic [1:0] bank;
    logic [17:0] addr;
  } mrp_cmd_pins_t;

  // Settings decoded from the base operating mode register.
  typedef struct packed {
    logic [4:0] write_recovery;
    logic [3:0] read_to_precharge_delay;
    logic [5:0] read_data_latency;
    logic burst_ordering;
    logic [1:0] burst_size_select;
    logic factory_test_select;
  } mrp_cfg_t;

  // One-hot states of the update sequencer.
  typedef enum logic [1:0] {
    MRP_IDLE = 2'b01,
    MRP_HOLD = 2'b10
  } mrp_state_t;
endpackage

// File: mrp_mode_regs_checker.sv
// Checker for the mode register programming block, bound to its top module.
// Assumes the block's core clock and reset; counts come in as parameters.
`timescale 1ns/1ps
`include "mrp_consts.svh"
module mrp_mode_regs_checker #(
  parameter int UPDATE_CYC = 2,
  parameter int GAP_NCK = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_clk,
  input wire mrp_pkg::mrp_cmd_pins_t cmd_pins,
  input wire logic [`MRP_NUM_REGS-1:0][`MRP_WORD_W-1:0] mode_regs,
  input wire mrp_pkg::mrp_cfg_t cfg,
  input wire logic dll_reset_pulse,
  input wire logic update_busy,
  input wire logic set_gap_error,
  input wire logic unused_select_seen,
  input wire logic reserved_code_seen
);
  import mrp_pkg::*;
  int busy_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Length of the busy stretch, so its end can be held to the update delay.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= update_busy ? busy_cnt + 1 : 0;
    end
  end
  sequence busy_end;
    $fell(update_busy);
  endsequence
  sequence base_taken;
    $changed(mode_regs[0]);
  endsequence
  busy_length_a: assert property (busy_end |-> busy_cnt == UPDATE_CYC)
    else $error("update delay length wrong");
  base_write_busy_a: assert property (base_taken |-> $rose(update_busy))
    else $error("base write without busy start");
  cfg_apply_time_a: assert property ($changed(cfg) |-> busy_end)
    else $error("settings applied outside update end");
  dll_with_busy_a: assert property (dll_reset_pulse |-> $rose(update_busy))
    else $error("dll pulse without base write");
  dll_pulse_once_a: assert property (dll_reset_pulse |=> !dll_reset_pulse)
    else $error("dll pulse too long");
  dll_bit_clear_a: assert property (mode_regs[0][`MRP_DLL_RST_BIT] == 1'b0)
    else $error("stored dll bit not cleared");
  unused_bits_a: assert property (mode_regs[6][16:14] == 3'h0)
    else $error("unmapped bits set");
  cfg_legal_a: assert property (
    cfg.burst_size_select != 2'h3 && cfg.read_data_latency >= 6'h09)
    else $error("reserved setting applied");
  gap_flag_sticky_a: assert property (set_gap_error |=> set_gap_error)
    else $error("gap flag dropped");
  unused_flag_sticky_a: assert property (unused_select_seen |=> unused_select_seen)
    else $error("unused select flag dropped");
endmodule
bind mrp_mode_regs mrp_mode_regs_checker #(.UPDATE_CYC(UPDATE_CYC), .GAP_NCK(GAP_NCK)) chk_u (
  .clk, .rst_n, .cmd_clk, .cmd_pins, .mode_regs, .cfg, .dll_reset_pulse, .update_busy,
  .set_gap_error, .unused_select_seen, .reserved_code_seen
);

// File: mrp_ctrl_model.sv
// Controller model: turns one request into one register set command frame.
// Assumes a free running command clock; the bench holds word until ack.
`timescale 1ns/1ps
module mrp_ctrl_model (
  input wire logic cmd_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [21:0] word,
  output logic ack,
  output mrp_pkg::mrp_cmd_pins_t cmd_pins
);
  import mrp_pkg::*;
  // This link carries no termination input, so the termination duties hold trivially.
  // Pins move on the falling edge so the device samples them settled.
  always_ff @(negedge cmd_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_pins <= '1;
      ack <= 1'b0;
    end else begin
      ack <= req && (ack || !cmd_pins.cs_n);
      if (req && !ack && cmd_pins.cs_n) begin
        cmd_pins <= {4'h0, 1'b1, word[21:17], 3'h0, word[13:0]};
      end else begin
        // Deselect; address lines flip so a stale value never looks valid.
        cmd_pins <= {4'hf, 1'b1, ~cmd_pins[21:0]};
      end
    end
  end
endmodule

// File: mode_register_programming_bench.sv
// Testbench for the mode register programming block with a controller model.
// Assumes the design, checker and model files are compiled ahead of it.
`timescale 1ns/1ps
module mode_register_programming_bench;
  import mrp_pkg::*;
  logic clk = 1'b0;
  logic cmd_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic [21:0] word = 22'h0;
  logic ack, dll_reset_pulse, update_busy, set_gap_error, unused_sel, rsv_seen;
  mrp_cmd_pins_t cmd_pins;
  logic [6:0][21:0] mode_regs;
  mrp_cfg_t cfg, exp_cfg;
  int mismatches = 0;
  int check_count = 0;
  int pulses = 0;
  int exp_pulses = 0;
  int lat [24] = '{9, 10, 11, 12, 13, 14, 15, 16, 18, 20, 22, 24, 23, 17, 19, 21, 25, 26, 27,
    28, 29, 30, 31, 32};
  int wr [10] = '{10, 12, 14, 16, 18, 20, 24, 22, 26, 28};
  // Two unrelated clocks: core at 40 ns, command at 64 ns with an offset.
  initial forever #20 clk = ~clk;
  initial begin
    #7;
    forever #32 cmd_clk = ~cmd_clk;
  end
  mrp_mode_regs #(.UPDATE_CYC(2), .GAP_NCK(8)) dut_u (.clk(clk), .rst_n(rst_n),
    .cmd_clk(cmd_clk), .cmd_pins(cmd_pins), .mode_regs(mode_regs), .cfg(cfg),
    .dll_reset_pulse(dll_reset_pulse), .update_busy(update_busy),
    .set_gap_error(set_gap_error), .unused_select_seen(unused_sel),
    .reserved_code_seen(rsv_seen));
  mrp_ctrl_model model_u (.cmd_clk(cmd_clk), .rst_n(rst_n), .req(req), .word(word),
    .ack(ack), .cmd_pins(cmd_pins));
  // Each pulse lasts one cycle, so counting them gives the number of resets.
  // Sampled on the falling edge, away from the edge that launches the pulse.
  always @(negedge clk) if (dll_reset_pulse === 1'b1) pulses++;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [21:0] exp, input logic [21:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One command through the model, then the caller's settle time; 16 keeps the spacing, 0 breaks it.
  task automatic mrs(input logic [21:0] w, input int settle);
    int n;
    n = 0;
    @(negedge clk);
    word = w;
    req = 1'b1;
    while (ack !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    req = 1'b0;
    while (ack !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) begin
      mismatches++;
      $display("mismatch handshake expected ack seen none");
      wrap_up();
    end
    // No set here touches a special function, so the plain gap and delay suffice.
    repeat (settle) @(negedge clk);
  endtask
  // Base word; bits 21, 17 and the test bit stay zero.
  function automatic logic [21:0] base(input logic [3:0] w, input logic [4:0] c,
    input logic [3:0] lo);
    // Test bit and reserved bits are always written as zero.
    return {5'h0, 3'h0, w[3], c[4], w[2:0], lo[3], 1'b0, c[3:1], lo[2], c[0],
      lo[1:0]};
  endfunction
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    exp_cfg = '{5'd10, 4'd5, 6'd9, 1'b0, 2'd0, 1'b0};
    chk("reset cfg", exp_cfg, cfg);
    chk("reset flags", 22'h0, {dll_reset_pulse, set_gap_error, unused_sel, rsv_seen});
    $display("reset test done");
    // Registers 1 to 6 get a full word here; the base register gets its words in the field loop.
    for (int i = 1; i < 7; i++) begin
      mrs({1'b0, 3'(i), 1'b1, 3'h0, 14'h2a5 + 14'(i)}, 16);
      chk("select", {1'b0, 3'(i), 1'b1, 3'h0, 14'h2a5 + 14'(i)}, mode_regs[i]);
    end
    $display("select test done");
    // Recovery never asks beyond 28/14 and gear-down stays off throughout.
    for (int k = 0; k < 24; k++) begin
      mrs(base(4'(k % 10), 5'(k), {k[1], k[0], 2'(k % 3)}), 16);
      exp_pulses += k[1];
      exp_cfg = '{5'(wr[k % 10]), 4'(wr[k % 10] / 2), 6'(lat[k]), k[0], 2'(k % 3), 1'b0};
      chk("fields", exp_cfg, cfg);
      chk("stored", base(4'(k % 10), 5'(k), {1'b0, k[0], 2'(k % 3)}), mode_regs[0]);
      chk("busy idle", 22'h0, 22'(update_busy));
    end
    chk("dll pulses", 22'(exp_pulses), 22'(pulses));
    $display("field test done");
    mrs(base(4'ha, 5'h18, {1'b0, exp_cfg.burst_ordering, 2'h3}), 16);
    chk("reserved keeps", exp_cfg, cfg);
    chk("reserved flag", 22'h1, rsv_seen);
    mrs({1'b0, 3'h7, 18'h0}, 16);
    chk("unused flag", 22'h1, unused_sel);
    chk("unused keeps", {1'b0, 3'h6, 1'b1, 3'h0, 14'h2ab}, mode_regs[6]);
    $display("refusal test done");
    mrs({1'b0, 3'h1, 18'h00011}, 0);
    mrs({1'b0, 3'h2, 18'h00022}, 16);
    chk("gap flag", 22'h1, set_gap_error);
    chk("late write", {1'b0, 3'h2, 18'h00022}, mode_regs[2]);
    $display("gap test done");
    wrap_up();
  end
endmodule
